// ==== hw/block_interrupt_aggregator.sv ====
/*
 * Block-level interrupt aggregator: block status and block enable
 * registers and the combined interrupt output.
 * Assumes every event input is already gated by its source-level enable
 * and that source status registers are read over the same register port.
 */
//
// Overview of operation
// [RULE1] Status bit 2 is set while the slip buffer block has a request.
// [RULE2] Status bit 2 clears after a read of the slip source register.
// [RULE3] Status bit 1 is set while the alarm block has a request.
// [RULE4] Status bit 1 clears after a read of an alarm source register.
// [RULE5] Status bit 0 is set while the framer block has a request.
// [RULE6] Status bit 0 clears after a read of the framer source register.
// [RULE7] Software reads the indicated source register to clear a bit.
// [RULE8] Enable bit 6 gates every loopback code interrupt.
// [RULE9] A block enable alone never raises the pin; the source must fire.
// [RULE10] Enable bit 5 gates the recovered clock loss interrupt.
// [RULE11] Enable bit 4 gates the one second interrupt.
// [RULE12] Enable bit 3 gates every link controller interrupt.
// [RULE13] Enable bits 2, 1 and 0 gate the slip, alarm and framer blocks.
// [RULE14] Status bit 6 flags loopback code, cleared by its source read.
// [RULE15] Status bit 3 flags the link block, cleared by a link read.
// [RULE16] Status bits 5 and 4 follow clock loss and one second levels.
// [RULE17] The interrupt is high while any status and enable pair is set.
`timescale 1ns/100ps

`include "blkirq_defines.svh"

module block_interrupt_aggregator (
    input  wire logic              CLK,
    input  wire logic              NRST,
    input  wire blkirq_pkg::addr_t ADDR,
    input  wire blkirq_pkg::byte_t WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic [7:0]             RDATA,
    output logic                   IRQ,
    input  wire logic              FRAMER_EVT,
    input  wire logic              ALARM_EVT,
    input  wire logic              SLIP_EVT,
    input  wire logic              LINK_EVT,
    input  wire logic              SECOND_TICK_LVL,
    input  wire logic              CLK_LOSS_LVL,
    input  wire logic              LOOP_CODE_EVT
);
    import blkirq_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    state_t state_r;
    state_t state_nxt;
    byte_t  set_vec;
    byte_t  clr_vec;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        set_vec = 8'h00;
        clr_vec = 8'h00;
        if (RD) begin
            case (ADDR)
                `FRAMER_SRC_ADDR: begin
                    clr_vec[`FRAMER_BIT] = 1'b1; // RULE6
                end
                `SLIP_SRC_ADDR: begin
                    clr_vec[`SLIP_BIT] = 1'b1; // RULE2
                end
                `LOOP_SRC_ADDR: begin
                    clr_vec[`LOOP_BIT] = 1'b1; // RULE14
                end
                `ALARM_SRC0_ADDR, `ALARM_SRC1_ADDR,
                `ALARM_SRC2_ADDR: begin
                    clr_vec[`ALARM_BIT] = 1'b1; // RULE4
                end
                `LINK_SRC0_ADDR, `LINK_SRC1_ADDR, `LINK_SRC2_ADDR,
                `LINK_SRC3_ADDR, `LINK_SRC4_ADDR,
                `LINK_SRC5_ADDR: begin
                    clr_vec[`LINK_BIT] = 1'b1; // RULE15
                end
                default: begin
                    clr_vec = 8'h00;
                end
            endcase
        end

        set_vec[`FRAMER_BIT] = FRAMER_EVT; // RULE5
        set_vec[`ALARM_BIT]  = ALARM_EVT; // RULE3
        set_vec[`SLIP_BIT]   = SLIP_EVT; // RULE1
        set_vec[`LINK_BIT]   = LINK_EVT; // RULE15
        set_vec[`LOOP_BIT]   = LOOP_CODE_EVT; // RULE14

        state_nxt = state_r;

        // The set term is applied last so that an event arriving in the
        // very cycle of the clearing read is kept, not lost.
        state_nxt.status = ((state_r.status & ~clr_vec) | set_vec)
                           & `BIRQ_STICKY_MASK;

        // These two are live conditions of the receive framer, so they
        // follow the level rather than latching.
        state_nxt.status[`CLKLOSS_BIT] = CLK_LOSS_LVL; // RULE16
        state_nxt.status[`SECOND_BIT]  = SECOND_TICK_LVL; // RULE16

        if (WR && (ADDR == `BIRQ_ENABLE_ADDR)) begin
            // Bit 7 is reserved: it is never stored and reads back as 0.
            state_nxt.enable = WDATA & `BIRQ_ENABLE_WMASK; // RULE13
            state_nxt.enable[`LOOP_BIT]    = WDATA[`LOOP_BIT]; // RULE8
            state_nxt.enable[`CLKLOSS_BIT] = WDATA[`CLKLOSS_BIT]; // RULE10
            state_nxt.enable[`SECOND_BIT]  = WDATA[`SECOND_BIT]; // RULE11
            state_nxt.enable[`LINK_BIT]    = WDATA[`LINK_BIT]; // RULE12
        end

        state_nxt.rdata = 8'h00;
        if (RD) begin
            case (ADDR)
                `BIRQ_STATUS_ADDR: begin
                    state_nxt.rdata = state_r.status;
                end
                `BIRQ_ENABLE_ADDR: begin
                    state_nxt.rdata = state_r.enable;
                end
                default: begin
                    state_nxt.rdata = 8'h00;
                end
            endcase
        end

        // Events only arrive once the source level let them through,
        // so a set enable with no source event leaves the pin low.
        // RULE9
        state_nxt.irq = |(state_nxt.status & state_nxt.enable); // RULE17
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_r.status <= `BIRQ_RESET_VALUE;
            state_r.enable <= `BIRQ_RESET_VALUE;
            state_r.rdata  <= 8'h00;
            state_r.irq    <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign RDATA = state_r.rdata;
    assign IRQ   = state_r.irq;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CLK);
    endclocking

    default disable iff (!NRST);

    sequence s_slip_read;
        RD && (ADDR == `SLIP_SRC_ADDR) && !SLIP_EVT;
    endsequence

    sequence s_alarm_read;
        RD && !ALARM_EVT &&
        ((ADDR == `ALARM_SRC0_ADDR) || (ADDR == `ALARM_SRC1_ADDR) ||
         (ADDR == `ALARM_SRC2_ADDR));
    endsequence

    sequence s_framer_read;
        RD && (ADDR == `FRAMER_SRC_ADDR) && !FRAMER_EVT;
    endsequence

    sequence s_enable_write;
        WR && (ADDR == `BIRQ_ENABLE_ADDR);
    endsequence

    sequence s_link_read;
        RD && !LINK_EVT &&
        ((ADDR == `LINK_SRC0_ADDR) || (ADDR == `LINK_SRC1_ADDR) ||
         (ADDR == `LINK_SRC2_ADDR) || (ADDR == `LINK_SRC3_ADDR) ||
         (ADDR == `LINK_SRC4_ADDR) || (ADDR == `LINK_SRC5_ADDR));
    endsequence

    sequence s_loop_read;
        RD && (ADDR == `LOOP_SRC_ADDR) && !LOOP_CODE_EVT;
    endsequence

    a_slip_set: assert property ( // RULE1
        SLIP_EVT |=> state_r.status[`SLIP_BIT])
        else $error("slip event did not set status bit 2");

    a_slip_clear: assert property ( // RULE2
        s_slip_read |=> !state_r.status[`SLIP_BIT])
        else $error("slip source read did not clear status bit 2");

    a_alarm_set: assert property ( // RULE3
        ALARM_EVT |=> state_r.status[`ALARM_BIT])
        else $error("alarm event did not set status bit 1");

    a_alarm_clear: assert property ( // RULE4
        s_alarm_read |=> !state_r.status[`ALARM_BIT])
        else $error("alarm source read did not clear status bit 1");

    a_framer_set: assert property ( // RULE5
        FRAMER_EVT |=> state_r.status[`FRAMER_BIT])
        else $error("framer event did not set status bit 0");

    a_framer_clear: assert property ( // RULE6
        s_framer_read |=> !state_r.status[`FRAMER_BIT])
        else $error("framer source read did not clear status bit 0");

    a_loop_gated: assert property ( // RULE8
        (!state_r.enable[`LOOP_BIT] && state_r.status == 8'h40)
        |-> !IRQ)
        else $error("loopback interrupt passed a cleared enable");

    a_pin_needs_event: assert property ( // RULE9
        (state_r.status == 8'h00) |-> !IRQ)
        else $error("interrupt raised with no pending block");

    a_clkloss_enable: assert property ( // RULE10
        s_enable_write |=> state_r.enable[`CLKLOSS_BIT] ==
                           $past(WDATA[`CLKLOSS_BIT]))
        else $error("enable bit 5 did not take the written value");

    a_second_enable: assert property ( // RULE11
        s_enable_write |=> state_r.enable[`SECOND_BIT] ==
                           $past(WDATA[`SECOND_BIT]))
        else $error("enable bit 4 did not take the written value");

    a_link_gated: assert property ( // RULE12
        (!state_r.enable[`LINK_BIT] && state_r.status == 8'h08)
        |-> !IRQ)
        else $error("link interrupt passed a cleared enable");

    a_low_enables: assert property ( // RULE13
        s_enable_write |=> state_r.enable[2:0] == $past(WDATA[2:0]))
        else $error("enable bits 2 to 0 did not take the written value");

    a_loop_sticky: assert property ( // RULE14
        LOOP_CODE_EVT ##1 !(RD && ADDR == `LOOP_SRC_ADDR)
        |=> state_r.status[`LOOP_BIT])
        else $error("loopback status bit did not hold until read");

    a_link_sticky: assert property ( // RULE15
        LINK_EVT |=> state_r.status[`LINK_BIT])
        else $error("link event did not set status bit 3");

    a_level_follow: assert property ( // RULE16
        ##1 (state_r.status[`CLKLOSS_BIT] == $past(CLK_LOSS_LVL)) &&
            (state_r.status[`SECOND_BIT] == $past(SECOND_TICK_LVL)))
        else $error("level status bits did not follow their inputs");

    a_irq_pairs: assert property ( // RULE17
        IRQ == |(state_r.status & state_r.enable))
        else $error("interrupt output disagrees with status and enable");

    a_read_once: assert property (
        (RD && ADDR == `BIRQ_ENABLE_ADDR) ##1 !RD
        |=> RDATA == 8'h00)
        else $error("read data stood longer than one cycle");

    a_loop_clear: assert property ( // RULE14
        s_loop_read |=> !state_r.status[`LOOP_BIT])
        else $error("loopback source read did not clear status bit 6");

    a_link_clear: assert property ( // RULE15
        s_link_read |=> !state_r.status[`LINK_BIT])
        else $error("link source read did not clear status bit 3");

    a_loop_enable: assert property ( // RULE8
        s_enable_write |=> state_r.enable[`LOOP_BIT] ==
                           $past(WDATA[`LOOP_BIT]))
        else $error("enable bit 6 did not take the written value");

    a_link_enable: assert property ( // RULE12
        s_enable_write |=> state_r.enable[`LINK_BIT] ==
                           $past(WDATA[`LINK_BIT]))
        else $error("enable bit 3 did not take the written value");

    a_enable_hold: assert property ( // RULE13
        !(WR && (ADDR == `BIRQ_ENABLE_ADDR))
        |=> $stable(state_r.enable))
        else $error("enable register changed without a write");

    a_slip_hold: assert property ( // RULE1
        (state_r.status[`SLIP_BIT] && !(RD && ADDR == `SLIP_SRC_ADDR))
        |=> state_r.status[`SLIP_BIT])
        else $error("slip status bit dropped before its source read");

    a_framer_hold: assert property ( // RULE5
        (state_r.status[`FRAMER_BIT] && !(RD && ADDR == `FRAMER_SRC_ADDR))
        |=> state_r.status[`FRAMER_BIT])
        else $error("framer status bit dropped before its source read");

    a_status_read: assert property ( // RULE16
        (RD && ADDR == `BIRQ_STATUS_ADDR)
        |=> RDATA == $past(state_r.status))
        else $error("status read returned the wrong value");

    a_reserved_zero: assert property ( // RULE13
        !state_r.enable[7] && !state_r.status[7])
        else $error("reserved bit 7 was found set");

    a_irq_masked: assert property ( // RULE9
        ((state_r.status & state_r.enable) == 8'h00) |-> !IRQ)
        else $error("interrupt raised with every pending block disabled");

    a_clkloss_gated: assert property ( // RULE10
        (!state_r.enable[`CLKLOSS_BIT] && state_r.status == 8'h20)
        |-> !IRQ)
        else $error("clock loss interrupt passed a cleared enable");

    a_second_gated: assert property ( // RULE11
        (!state_r.enable[`SECOND_BIT] && state_r.status == 8'h10)
        |-> !IRQ)
        else $error("one second interrupt passed a cleared enable");

endmodule

// ==== shared/blkirq_defines.svh ====
/*
 * Register offsets, bit positions, reset values and address constants
 * for the block interrupt aggregator.
 * Assumes a 16-bit byte address bus with one register per address.
 */
`ifndef BLKIRQ_DEFINES_SVH
`define BLKIRQ_DEFINES_SVH

// ****************************************************************
// Own registers
// ****************************************************************
`define BIRQ_STATUS_ADDR  16'h0b00
`define BIRQ_ENABLE_ADDR  16'h0b01
`define BIRQ_RESET_VALUE  8'h00
`define BIRQ_ENABLE_WMASK 8'h7f
`define BIRQ_STICKY_MASK  8'h4f

// ****************************************************************
// Source status registers whose reads clear a block bit
// ****************************************************************
`define FRAMER_SRC_ADDR   16'h0b04
`define SLIP_SRC_ADDR     16'h0b08
`define LOOP_SRC_ADDR     16'h0b0a
`define ALARM_SRC0_ADDR   16'h0b02
`define ALARM_SRC1_ADDR   16'h0b0e
`define ALARM_SRC2_ADDR   16'h0b40
`define LINK_SRC0_ADDR    16'h0b06
`define LINK_SRC1_ADDR    16'h0b16
`define LINK_SRC2_ADDR    16'h0b26
`define LINK_SRC3_ADDR    16'h0b10
`define LINK_SRC4_ADDR    16'h0b18
`define LINK_SRC5_ADDR    16'h0b28

// ****************************************************************
// Bit positions, shared by status and enable
// ****************************************************************
`define FRAMER_BIT        0
`define ALARM_BIT         1
`define SLIP_BIT          2
`define LINK_BIT          3
`define SECOND_BIT        4
`define CLKLOSS_BIT       5
`define LOOP_BIT          6

`endif

// ==== shared/blkirq_pkg.sv ====
/*
 * Types for the block interrupt aggregator.
 * Assumes blkirq_defines.svh holds every numeric constant.
 */
package blkirq_pkg;

    typedef logic [15:0] addr_t;
    typedef logic [7:0]  byte_t;

    typedef struct packed {
        byte_t status;
        byte_t enable;
        byte_t rdata;
        logic  irq;
    } state_t;

endpackage

// ==== verification/host_model.sv ====
/*
 * Host processor model: register port cycles and interrupt service.
 * Assumes one clock and that the bench calls one task at a time.
 */
`timescale 1ns/100ps

`include "blkirq_defines.svh"

module host_model (
    input  wire logic              clk,
    output blkirq_pkg::addr_t      addr,
    output blkirq_pkg::byte_t      wdata,
    output logic                   wr,
    output logic                   rd,
    input  wire blkirq_pkg::byte_t rdata
);
    import blkirq_pkg::*;

    // ****************************************************************
    // Register port cycles
    // ****************************************************************
    initial begin
        addr  = 16'h0000;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // Released lines are inverted so a stale value never looks valid.
    task automatic write_reg(input addr_t a, input byte_t d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        addr  <= ~a;
        wdata <= ~d;
        #1;
    endtask

    task automatic read_reg(input addr_t a, output byte_t d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask

    // ****************************************************************
    // Interrupt service
    // ****************************************************************
    // Only the source read clears a block bit, so each set sticky bit (0 to 3 and 6) is chased.
    task automatic service;
        byte_t s;
        byte_t d;
        read_reg(`BIRQ_STATUS_ADDR, s);
        if (s[`FRAMER_BIT]) read_reg(`FRAMER_SRC_ADDR, d);
        if (s[`ALARM_BIT]) read_reg(`ALARM_SRC0_ADDR, d);
        if (s[`SLIP_BIT]) read_reg(`SLIP_SRC_ADDR, d);
        if (s[`LINK_BIT]) read_reg(`LINK_SRC0_ADDR, d);
        if (s[`LOOP_BIT]) read_reg(`LOOP_SRC_ADDR, d);
    endtask
endmodule

// ==== verification/tb.sv ====
/*
 * Self-checking bench for the block interrupt aggregator.
 * Assumes the host model drives the register port and the bench
 * drives the event and level inputs.
 */
`timescale 1ns/100ps

`include "blkirq_defines.svh"

module tb;
    import blkirq_pkg::*;

    logic       clk;
    logic       nrst;
    addr_t      addr;
    byte_t      wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       irq;
    logic [6:0] src;
    byte_t      v;
    int         err_total;
    int         n_compared;
    int         cycles;
    addr_t      clr_addr [12] = '{16'h0b04, 16'h0b02, 16'h0b0e, 16'h0b40,
        16'h0b08, 16'h0b06, 16'h0b16, 16'h0b26, 16'h0b10, 16'h0b18,
        16'h0b28, 16'h0b0a};
    int         clr_bit [12] = '{0, 1, 1, 1, 2, 3, 3, 3, 3, 3, 3, 6};

    host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata));

    block_interrupt_aggregator dut (.CLK(clk), .NRST(nrst), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq),
        .FRAMER_EVT(src[0]), .ALARM_EVT(src[1]), .SLIP_EVT(src[2]),
        .LINK_EVT(src[3]), .SECOND_TICK_LVL(src[4]),
        .CLK_LOSS_LVL(src[5]), .LOOP_CODE_EVT(src[6]));

    // ****************************************************************
    // Checks and helpers
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk8(input byte_t got, input byte_t exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic pulse(input int b);
        @(posedge clk);
        src[b] <= 1'b1;
        @(posedge clk);
        src[b] <= 1'b0;
        #1;
    endtask

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // A hang in any wait ends the run as a mismatch.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            give_verdict();
        end
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        nrst = 1'b0;
        src = 7'h00;
        err_total = 0;
        n_compared = 0;
        cycles = 0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        host.read_reg(`BIRQ_STATUS_ADDR, v);
        chk8(v, `BIRQ_RESET_VALUE);
        host.read_reg(`BIRQ_ENABLE_ADDR, v);
        chk8(v, `BIRQ_RESET_VALUE);
        chk1(irq, 1'b0);
        host.write_reg(`BIRQ_ENABLE_ADDR, 8'hff);
        host.read_reg(`BIRQ_ENABLE_ADDR, v);
        chk8(v, `BIRQ_ENABLE_WMASK);
        chk1(irq, 1'b0);
        host.write_reg(`BIRQ_STATUS_ADDR, 8'hff);
        host.read_reg(`BIRQ_STATUS_ADDR, v);
        chk8(v, 8'h00);
        host.read_reg(16'h0b03, v);
        chk8(v, 8'h00);
        for (int i = 0; i < 12; i++) begin
            host.write_reg(`BIRQ_ENABLE_ADDR, 8'h00);
            pulse(clr_bit[i]);
            chk1(irq, 1'b0);
            host.write_reg(`BIRQ_ENABLE_ADDR, byte_t'(8'h01 << clr_bit[i]));
            chk1(irq, 1'b1);
            host.read_reg(`BIRQ_STATUS_ADDR, v);
            chk8(v, byte_t'(8'h01 << clr_bit[i]));
            host.read_reg(clr_addr[i], v);
            host.read_reg(`BIRQ_STATUS_ADDR, v);
            chk8(v, 8'h00);
            chk1(irq, 1'b0);
        end
        for (int b = 4; b < 6; b++) begin
            host.write_reg(`BIRQ_ENABLE_ADDR, 8'h00);
            @(posedge clk);
            src[b] <= 1'b1;
            host.read_reg(`BIRQ_STATUS_ADDR, v);
            chk8(v, byte_t'(8'h01 << b));
            chk1(irq, 1'b0);
            host.write_reg(`BIRQ_ENABLE_ADDR, byte_t'(8'h01 << b));
            chk1(irq, 1'b1);
            @(posedge clk);
            src[b] <= 1'b0;
            host.read_reg(`BIRQ_STATUS_ADDR, v);
            chk8(v, 8'h00);
            chk1(irq, 1'b0);
        end
        host.write_reg(`BIRQ_ENABLE_ADDR, 8'h4f);
        pulse(0);
        pulse(6);
        chk1(irq, 1'b1);
        host.service();
        host.read_reg(`BIRQ_STATUS_ADDR, v);
        chk8(v, 8'h00);
        chk1(irq, 1'b0);
        // An event in the very cycle of its clearing read must survive.
        fork
            host.read_reg(`SLIP_SRC_ADDR, v);
            pulse(2);
        join
        host.read_reg(`BIRQ_STATUS_ADDR, v);
        chk8(v, 8'h04);
        chk1(irq, 1'b1);
        host.read_reg(`SLIP_SRC_ADDR, v);
        host.read_reg(`BIRQ_STATUS_ADDR, v);
        chk8(v, 8'h00);
        chk1(irq, 1'b0);
        give_verdict();
    end
endmodule
